// *** pcm_glitch_filter.sv ***
// One pin's input glitch filter with bypass
`timescale 1ns/1ps
`default_nettype none
module pcm_glitch_filter
   import pcm_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic tick_in,
   input wire logic [FILT_W-1:0] samples_in,
   input wire logic raw_in,
   output logic filt_out
);
   logic [FILT_W:0] cnt_q;
   logic level_q;
   logic differs;
   assign differs = raw_in != level_q;
   // Level must hold for samples_in + 1 ticks before it is accepted
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
         level_q <= 1'b1;
      end else if (!differs) begin
         cnt_q <= '0;
      end else if (tick_in) begin
         if (cnt_q >= {1'b0, samples_in}) begin
            level_q <= raw_in;
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
   assign filt_out = (samples_in == FILT_BYPASS) ? raw_in : level_q;
endmodule
`default_nettype wire

// *** pcm_pad_model.sv ***
// Board-side model of the pads: drivers, pulls and floating pins
`timescale 1ns/1ps
`default_nettype none
module pcm_pad_model
   import pcm_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic [NUM_PINS-1:0] drv_in,
   input wire logic [NUM_PINS-1:0] oe_in,
   input wire logic [NUM_PINS-1:0] pu_in,
   input wire logic [NUM_PINS-1:0] pd_in,
   input wire logic [NUM_PINS-1:0] ext_en_in,
   input wire logic [NUM_PINS-1:0] ext_val_in,
   output logic [NUM_PINS-1:0] pad_out
);
   logic [NUM_PINS-1:0] last_q = '0;
   always @(posedge clk_sys_in) last_q <= pad_out;
   // Floating pins wander, so a stale level never passes for a real one
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (oe_in[i]) pad_out[i] = drv_in[i];
         else if (ext_en_in[i]) pad_out[i] = ext_val_in[i];
         else if (pu_in[i] != pd_in[i]) pad_out[i] = pu_in[i];
         else pad_out[i] = ~last_q[i];
      end
   end
endmodule
`default_nettype wire

// *** pcm_pin_matrix.sv ***
// Pin configuration and pin function matrix top level
`timescale 1ns/1ps
`default_nettype none
module pcm_pin_matrix
   import pcm_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Per-pin configuration
   input wire logic cfg_we_in,
   input wire logic [NUM_PINS-1:0] pullup_en_in,
   input wire logic [NUM_PINS-1:0] pulldown_en_in,
   input wire logic [NUM_PINS-1:0] pseudo_od_in,
   input wire logic [NUM_PINS-1:0] invert_in,
   input wire logic [NUM_PINS-1:0] repeater_in,
   input wire logic [NUM_PINS-1:0] analog_en_in,
   input wire logic [NUM_PINS*FDIV_W-1:0] filt_clk_sel_in,
   input wire logic [NUM_PINS*FILT_W-1:0] filt_samples_in,
   input wire logic [1:0] od_a_mode_in,
   input wire logic [1:0] od_b_mode_in,
   input wire logic [NUM_FDIV-1:0] fdiv_tick_in,
   // Function matrix
   input wire logic mat_we_in,
   input wire logic [NUM_MOV_OUT*PIN_W-1:0] mov_out_pin_in,
   input wire logic [NUM_MOV_IN*PIN_W-1:0] mov_in_pin_in,
   input wire logic [NUM_PINS-1:0] port_en_in,
   // Peripheral side
   input wire logic [NUM_MOV_OUT-1:0] mov_out_val_in,
   input wire logic [NUM_MOV_OUT-1:0] mov_out_oe_in,
   input wire logic pattern_match_in,
   output logic [NUM_MOV_IN-1:0] mov_in_val_out,
   input wire logic [NUM_PINS-1:0] port_out_val_in,
   input wire logic [NUM_PINS-1:0] port_dir_in,
   output logic [NUM_PINS-1:0] port_in_val_out,
   // Pad side
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe_out,
   output logic [NUM_PINS-1:0] pad_pullup_out,
   output logic [NUM_PINS-1:0] pad_pulldown_out,
   output logic [NUM_PINS-1:0] pad_analog_out,
   output logic [1:0] od_a_mode_out,
   output logic [1:0] od_b_mode_out
);
   logic [NUM_PINS-1:0] pu_q, pd_q, pod_q, inv_q, rep_q, ana_q, port_en_q;
   logic [NUM_PINS*FDIV_W-1:0] fsel_q;
   logic [NUM_PINS*FILT_W-1:0] fsam_q;
   logic [1:0] oda_q, odb_q;
   logic [NUM_MOV_OUT*PIN_W-1:0] mo_q;
   logic [NUM_MOV_IN*PIN_W-1:0] mi_q;
   logic [NUM_PINS-1:0] last_q, last_d;
   logic [NUM_PINS-1:0] filt, din, mov_hit, mov_val, drv_oe, drv_val;
   logic [NUM_MOV_OUT-1:0] mov_src_val, mov_src_oe;
   logic [NUM_PINS-1:0] od_mask, ana_mask, mov_sel;

   function automatic logic [PIN_W-1:0] pin_of(
      input logic [NUM_MOV_OUT*PIN_W-1:0] v, input int k);
      pin_of = v[k*PIN_W +: PIN_W];
   endfunction

   assign od_mask = (18'h0_0001 << OD_PIN_A) | (18'h0_0001 << OD_PIN_B);
   assign ana_mask = ANALOG_CAPABLE;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pu_q <= PULLUP_RST;
         pd_q <= ZERO_RST;
         pod_q <= ZERO_RST;
         inv_q <= ZERO_RST;
         rep_q <= ZERO_RST;
         ana_q <= ZERO_RST;
         fsel_q <= '0;
         fsam_q <= '0;
         oda_q <= PCM_I2C_STD_IO;
         odb_q <= PCM_I2C_STD_IO;
      end else if (cfg_we_in) begin
         pu_q <= pullup_en_in & ~od_mask;
         pd_q <= pulldown_en_in & ~od_mask;
         pod_q <= pseudo_od_in;
         inv_q <= invert_in;
         rep_q <= repeater_in;
         ana_q <= analog_en_in & ana_mask;
         fsel_q <= filt_clk_sel_in;
         fsam_q <= filt_samples_in;
         oda_q <= od_a_mode_in == 2'h3 ? PCM_I2C_STD_IO : od_a_mode_in;
         odb_q <= od_b_mode_in == 2'h3 ? PCM_I2C_STD_IO : od_b_mode_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         port_en_q <= PORT_EN_RST;
         mo_q <= {NUM_MOV_OUT{PIN_NONE}};
         mi_q <= {NUM_MOV_IN{PIN_NONE}};
      end else if (mat_we_in) begin
         port_en_q <= port_en_in;
         mo_q <= mov_out_pin_in;
         mi_q <= mov_in_pin_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         last_q <= '1;
      end else begin
         last_q <= last_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slot 7 carries the pattern match result instead of a peripheral
   assign mov_src_val = {pattern_match_in, mov_out_val_in[NUM_MOV_OUT-2:0]};
   assign mov_src_oe = {1'b1, mov_out_oe_in[NUM_MOV_OUT-2:0]};

   genvar p;
   generate
      for (p = 0; p < NUM_PINS; p++) begin : g_pin
         logic hit, val;
         logic [FDIV_W-1:0] sel;
         always_comb begin
            hit = 1'b0;
            val = 1'b0;
            for (int k = 0; k < NUM_MOV_OUT; k++) begin
               if (pin_of(mo_q, k) == PIN_W'(p) && !hit) begin
                  hit = mov_src_oe[k];
                  val = mov_src_val[k];
               end
            end
         end
         // Enabled fixed function owns the pin; else movable may take it
         assign mov_hit[p] = hit && !port_en_q[p];
         assign mov_val[p] = val;
         assign sel = fsel_q[p*FDIV_W +: FDIV_W];
         pcm_glitch_filter u_filt (
            .clk_sys_in(clk_sys_in),
            .rst_n_in(rst_n_in),
            .tick_in(sel < FDIV_W'(NUM_FDIV) ? fdiv_tick_in[sel] : 1'b0),
            .samples_in(fsam_q[p*FILT_W +: FILT_W]),
            .raw_in(pad_in[p]),
            .filt_out(filt[p])
         );
      end
   endgenerate

   // Enabled port output wins over a movable output on the same pin
   // Per-pin select; a vector condition would pick one source for all pins
   assign mov_sel = mov_hit | ~port_en_q;
   assign drv_val = (mov_sel & mov_val) |
      (~mov_sel & port_out_val_in);
   assign drv_oe = mov_hit | (port_en_q & port_dir_in);
   assign din = (filt ^ inv_q) & ~ana_q;
   assign last_d = (drv_oe & drv_val) | (~drv_oe & pad_in);

   always_comb begin
      for (int m = 0; m < NUM_MOV_IN; m++) begin
         mov_in_val_out[m] = 1'b0;
         for (int q = 0; q < NUM_PINS; q++) begin
            if (mi_q[m*PIN_W +: PIN_W] == PIN_W'(q)) begin
               mov_in_val_out[m] = din[q];
            end
         end
      end
   end

   assign port_in_val_out = din & port_en_q;
   // Pseudo and true open-drain drive low only; analog cuts the driver
   assign pad_out = drv_val & ~pod_q & ~od_mask;
   assign pad_oe_out = drv_oe & ~ana_q &
      (~(pod_q | od_mask) | ~drv_val);
   // Repeater: weak pull toward the last level
   assign pad_pullup_out = (pu_q | (rep_q & last_q)) & ~ana_q;
   assign pad_pulldown_out = (pd_q | (rep_q & ~last_q)) & ~ana_q;
   assign pad_analog_out = ana_q;
   assign od_a_mode_out = oda_q;
   assign od_b_mode_out = odb_q;

   ////////////////////////////////////////////////////////////////////////
   reset_pullup_a: assert property (@(posedge clk_sys_in)
      $rose(rst_n_in) |-> pad_pullup_out == PULLUP_RST)
      else $error("pull-up state after reset wrong");
   reset_port_a: assert property (@(posedge clk_sys_in)
      $rose(rst_n_in) |-> port_en_q == PORT_EN_RST)
      else $error("port enables after reset wrong");
   analog_cut_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (pad_oe_out & ana_q) == '0 && (port_in_val_out & ana_q) == '0)
      else $error("analog pin still digital");
   pseudo_od_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (pad_out & pod_q) == '0)
      else $error("pseudo open-drain drives high");
   od_pull_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (pu_q & od_mask) == '0 && (pd_q & od_mask) == '0)
      else $error("open-drain pin has pull");
   od_mode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      cfg_we_in ##1 1'b1 |-> oda_q != 2'h3 && odb_q != 2'h3)
      else $error("illegal driver mode");
   mov_wins_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (drv_val & mov_hit) == (mov_val & mov_hit))
      else $error("port output overrode movable output");
   match_route_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      pin_of(mo_q, MOV_PATTERN_MATCH) == 5'h00 && !port_en_q[0]
      && !ana_q[0] && !pod_q[0] |-> pad_out[0] == pattern_match_in)
      else $error("pattern match not routed");
endmodule
`default_nettype wire

// *** pcm_pkg.sv ***
// Constants and types for the pin configuration and function matrix
// Operation
// - Each ordinary pin has independent pull-up and pull-down enables.
// - Each configurable pin offers pseudo open-drain: drive low only.
// - Inputs pass a glitch filter on a selectable divided clock; bypassable.
// - Each pin can invert its input before internal functions.
// - Repeater mode keeps last level, ORed with the pull-up and pull-down enables.
// - Open-drain pins select standard, I2C standard/fast, or Fast-mode Plus.
// - Analog mode on mixed pins disconnects all digital input and output.
// - Any movable signal may be routed to any non-supply pin.
// - Fixed-pin functions sit on one pin, each enabled individually.
// - A disabled fixed-pin function frees its pin for movable functions.
// - Pattern match result is a movable output routable to a pin.
// - After reset port function is on except debug data, clock, reset.
// - After reset all non open-drain pins are inputs with pull-up on.
package pcm_pkg;
   localparam int NUM_PINS = 18;
   localparam int PIN_W = 5;
   localparam int NUM_MOV_OUT = 8;
   localparam int NUM_MOV_IN = 8;
   localparam int NUM_FDIV = 7;
   localparam int FDIV_W = 3;
   localparam int FILT_W = 2;
   localparam int OD_PIN_A = 10;
   localparam int OD_PIN_B = 11;
   localparam int DBG_DATA_PIN = 2;
   localparam int DBG_CLK_PIN = 3;
   localparam int RESET_PIN = 5;
   localparam logic [PIN_W-1:0] PIN_NONE = 5'h1f;
   localparam int MOV_PATTERN_MATCH = 7;
   localparam logic [NUM_PINS-1:0] ANALOG_CAPABLE = 18'h0_00c3;
   localparam logic [NUM_PINS-1:0] PORT_EN_RST = 18'h3_ffd3;
   localparam logic [NUM_PINS-1:0] PULLUP_RST = 18'h3_f3ff;
   localparam logic [NUM_PINS-1:0] ZERO_RST = 18'h0_0000;
   localparam logic [FILT_W-1:0] FILT_BYPASS = 2'h0;
   typedef enum logic [1:0] {
      PCM_I2C_STD_IO = 2'b00,
      PCM_I2C_FAST = 2'b01,
      PCM_I2C_FMPLUS = 2'b10
   } pcm_i2c_mode_t;
endpackage

// *** testbench.sv ***
// Self-checking bench for the pin configuration and function matrix
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pcm_pkg::*;
   logic clk_sys_in = 0, rst_n_in = 0, cfg_we = 0, mat_we = 0, pm = 0;
   logic [NUM_PINS-1:0] pu = PULLUP_RST, pd = '0, pod = '0, inv = '0;
   logic [NUM_PINS-1:0] rep = '0, ana = '0, pen = PORT_EN_RST;
   logic [NUM_PINS-1:0] pov = '0, pdir = '0, ext_en = '0, ext_val = '0;
   logic [NUM_PINS-1:0] pad_in, pad_o, pad_oe, pad_pu, pad_pd, pad_ana;
   logic [NUM_PINS-1:0] port_in;
   logic [NUM_PINS*FDIV_W-1:0] fsel = '0;
   logic [NUM_PINS*FILT_W-1:0] fsam = '0;
   logic [1:0] moda = '0, modb = '0, moda_o, modb_o;
   logic [NUM_FDIV-1:0] tick = '0;
   logic [NUM_MOV_OUT*PIN_W-1:0] mout = {NUM_MOV_OUT{PIN_NONE}};
   logic [NUM_MOV_IN*PIN_W-1:0] mpin = {NUM_MOV_IN{PIN_NONE}};
   logic [NUM_MOV_OUT-1:0] mval = '0, moe = '0;
   logic [NUM_MOV_IN-1:0] mv_in;
   int mismatches = 0, n_tests = 0;
   pcm_pin_matrix i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .cfg_we_in(cfg_we), .pullup_en_in(pu), .pulldown_en_in(pd),
      .pseudo_od_in(pod), .invert_in(inv), .repeater_in(rep),
      .analog_en_in(ana), .filt_clk_sel_in(fsel), .filt_samples_in(fsam),
      .od_a_mode_in(moda), .od_b_mode_in(modb), .fdiv_tick_in(tick),
      .mat_we_in(mat_we), .mov_out_pin_in(mout), .mov_in_pin_in(mpin),
      .port_en_in(pen), .mov_out_val_in(mval), .mov_out_oe_in(moe),
      .pattern_match_in(pm), .mov_in_val_out(mv_in),
      .port_out_val_in(pov), .port_dir_in(pdir), .port_in_val_out(port_in),
      .pad_in(pad_in), .pad_out(pad_o), .pad_oe_out(pad_oe),
      .pad_pullup_out(pad_pu), .pad_pulldown_out(pad_pd),
      .pad_analog_out(pad_ana), .od_a_mode_out(moda_o),
      .od_b_mode_out(modb_o));
   pcm_pad_model i_pads (.clk_sys_in(clk_sys_in), .drv_in(pad_o),
      .oe_in(pad_oe), .pu_in(pad_pu), .pd_in(pad_pd), .ext_en_in(ext_en),
      .ext_val_in(ext_val), .pad_out(pad_in));
   initial begin
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   task automatic check(input string name, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Caller sets the new values at a rising edge just before this
   task automatic load(input bit mat);
      if (mat) mat_we <= 1'b1;
      else cfg_we <= 1'b1;
      @(posedge clk_sys_in);
      cfg_we <= 1'b0;
      mat_we <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_sys_in) tick <= 7'h01;
         @(posedge clk_sys_in) tick <= 7'h00;
      end
      @(negedge clk_sys_in);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(negedge clk_sys_in);
      check("pullups", pad_pu, PULLUP_RST);
      check("oe", pad_oe, ZERO_RST);
      check("port", port_in & 18'h3_f3ff, PORT_EN_RST & 18'h3_f3ff);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_sys_in);
         {pu, pd, ana, pdir, pov} <= {5{18'h3_ffff}};
         moda <= 2'(m);
         modb <= 2'(3 - m);
         load(0);
         check("mode a", moda_o, (m == 3) ? 0 : m);
         check("mode b", modb_o, (m == 0) ? 0 : 3 - m);
      end
      check("pu", pad_pu, PULLUP_RST & ~ANALOG_CAPABLE);
      check("pd", pad_pd, PULLUP_RST & ~ANALOG_CAPABLE);
      check("analog", pad_ana, ANALOG_CAPABLE);
      check("ana in", port_in & ANALOG_CAPABLE, 0);
      check("ana oe", pad_oe & ANALOG_CAPABLE, 0);
      // Pin 4 push-pull, 8/9 pseudo open-drain, 10/11 true open-drain
      @(posedge clk_sys_in);
      {pd, ana} <= '0;
      pu <= PULLUP_RST;
      pod <= 18'h0_0300;
      pdir <= 18'h0_0f10;
      pov <= 18'h0_0510;
      load(0);
      check("od oe", pad_oe & 18'h0_0f10, 18'h0_0a10);
      check("od val", pad_o & 18'h0_0a10, 18'h0_0010);
      @(posedge clk_sys_in);
      mout <= {PIN_W'(0), {6{PIN_NONE}}, PIN_W'(4)};
      mpin <= {{7{PIN_NONE}}, PIN_W'(12)};
      pen <= PORT_EN_RST & 18'h3_ffee;
      {mval[0], moe[0], pm, ext_en[12]} <= 4'b1111;
      load(1);
      check("mov oe", {pad_oe[4], pad_o[4]}, 2'b11);
      check("match", pad_o[0], 1'b1);
      check("mov in", mv_in[1:0], 2'b00);
      check("port off", {port_in[4], port_in[0]}, 2'b00);
      @(posedge clk_sys_in);
      {mval[0], pm, ext_val[12]} <= 3'b001;
      @(negedge clk_sys_in);
      check("mov val", {pad_o[4], pad_o[0]}, 2'b00);
      check("mov in hi", mv_in[0], 1'b1);
      // Repeater on pin 13 with its pull-up removed
      @(posedge clk_sys_in);
      pu[13] <= 1'b0;
      rep[13] <= 1'b1;
      {ext_en[13], ext_val[13]} <= 2'b10;
      load(0);
      check("rep low", {pad_pu[13], pad_pd[13]}, 2'b01);
      @(posedge clk_sys_in) ext_val[13] <= 1'b1;
      repeat (3) @(negedge clk_sys_in);
      check("rep high", {pad_pu[13], pad_pd[13]}, 2'b10);
      @(posedge clk_sys_in) ext_en[13] <= 1'b0;
      repeat (3) @(negedge clk_sys_in);
      check("rep keep", port_in[13], 1'b1);
      // Filter on pin 1 with one sample, inverter on pin 7
      @(posedge clk_sys_in);
      fsam[FILT_W+:FILT_W] <= 2'h1;
      inv[7] <= 1'b1;
      {ext_en[1], ext_val[1]} <= 2'b10;
      load(0);
      check("invert", port_in[7], 1'b0);
      check("filt hold", port_in[1], 1'b1);
      ticks(1);
      check("filt 1 tick", port_in[1], 1'b1);
      ticks(1);
      check("filt pass", port_in[1], 1'b0);
      @(posedge clk_sys_in) fsam <= '0;
      load(0);
      @(posedge clk_sys_in) ext_val[1] <= 1'b1;
      @(negedge clk_sys_in);
      check("bypass", port_in[1], 1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
